// [dv/acc_counters_bench.sv]
// Self-checking testbench for the ATM cell traffic counters block.
`timescale 1ns/10ps
module acc_counters_bench;
  // Rows of register index beside the value expected after reset.
  typedef struct {logic [7:0] idx; logic [15:0] exp;} acc_row_t;
  acc_row_t rows [16] = '{'{8'h18,16'hfffc}, '{8'h19,16'hfffc}, '{8'h1a,16'hfffc}, '{8'h1b,16'hfffc},
    '{8'h1c,16'hfffc}, '{8'h1d,16'hfffc}, '{8'h1e,16'hfffc}, '{8'h1f,16'hfffc}, '{8'h20,16'hfffc},
    '{8'h21,16'hfffc}, '{8'h22,16'hfffc}, '{8'h23,16'hfffc}, '{8'h55,16'h0000}, '{8'h60,16'h0000},
    '{8'h61,16'h0000}, '{8'h40,16'h0000}};
  logic        CLK_SYS = 1'b0;       // Core clock, 5 ns period.
  logic        RST = 1'b1;           // Reset, held at the start.
  logic        HSEL = 1'b0;          // Bus select.
  logic [31:0] HADDR = 32'h0;        // Byte address.
  logic [1:0]  HTRANS = 2'h0;        // Transfer type.
  logic        HWRITE = 1'b0;        // Write flag.
  logic [31:0] HWDATA = 32'h0;       // Write data.
  logic [31:0] HRDATA;               // Read data.
  logic        HREADYOUT;            // Slave ready, also the bus ready.
  logic        HRESP;                // Slave response.
  logic [3:0]  TX_ASSIGNED = 4'h0;   // Assigned cell sent pulses.
  logic [3:0]  TX_SLOT = 4'h0;       // Cell slot due pulses.
  logic [3:0]  TX_BUF_EMPTY = 4'hf;  // Empty buffer levels.
  logic [3:0]  RX_ASSIGNED = 4'h0;   // Assigned cell received pulses.
  logic [3:0]  TX_IDLE_INSERT;       // Idle insert request.
  logic        IRQ;                  // Interrupt level.
  logic [31:0] rdat;                 // Data taken at the close of a data phase.
  logic [3:0]  ins;                  // Idle insert seen during a cell burst.
  int          num_errors = 0;       // Mismatches.
  int          total_checks = 0;     // Comparisons.

  // Free-running clock.
  always #2.5 CLK_SYS = ~CLK_SYS;

  acc_counters u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_ASSIGNED(TX_ASSIGNED), .TX_SLOT(TX_SLOT),
    .TX_BUF_EMPTY(TX_BUF_EMPTY), .RX_ASSIGNED(RX_ASSIGNED), .TX_IDLE_INSERT(TX_IDLE_INSERT), .IRQ(IRQ));

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for ready at a rising edge and takes read data at that edge; only the watchdog ends a hang.
  task automatic wait_rdy();
    do begin
      @(posedge CLK_SYS);
    end while (HREADYOUT !== 1'b1);
    rdat = HRDATA;
  endtask

  // One single word transfer; entered and left just after a rising edge.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {22'h0, idx, 2'b00};
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_rdy();
  endtask

  // Holds the cell pulses for n edges, noting the idle insert request on the way.
  task automatic cells(input logic [3:0] a, input logic [3:0] s, input logic [3:0] r, input int n);
    TX_ASSIGNED <= a;
    TX_SLOT <= s;
    RX_ASSIGNED <= r;
    @(negedge CLK_SYS);
    ins = TX_IDLE_INSERT;
    repeat (n - 1) @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    TX_ASSIGNED <= 4'h0;
    TX_SLOT <= 4'h0;
    RX_ASSIGNED <= 4'h0;
  endtask

  // Reads all twelve counters; after a step only the counter with channel equal to group holds one.
  task automatic read_all(input logic step);
    for (int g = 0; g < 3; g++) begin
      for (int ch = 0; ch < 4; ch++) begin
        bus(1'b0, 8'h18 + 8'(4 * g + 3 - ch), 32'h0);
        chk(rdat, {31'h0, step && (ch == g)});
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog sized well beyond the fifty-five transfers of the run.
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    num_errors++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].idx, 32'h0);
      chk(rdat, {16'h0, rows[i].exp});
    end
    chk(HRESP, 1'b0);
    // A write to a counter must leave it untouched.
    bus(1'b1, 8'h1b, 32'h0000_1234);
    bus(1'b0, 8'h1b, 32'h0);
    chk(rdat, 32'h0000_fffc);
    // Three cells bring every counter to the top without a roll-over flag.
    cells(4'hf, 4'hf, 4'hf, 3);
    chk(ins, 4'hf);
    bus(1'b0, 8'h55, 32'h0);
    chk(rdat, 32'h0);
    // The fourth cell wraps all twelve and raises their flags in one register.
    cells(4'hf, 4'hf, 4'hf, 1);
    bus(1'b0, 8'h55, 32'h0);
    chk(rdat, 32'h0000_fff0);
    read_all(1'b0);
    cells(4'h1, 4'h2, 4'h4, 1);
    read_all(1'b1);
    // Flags set but masked keep the interrupt low; unmasking raises it, clearing drops it.
    chk(IRQ, 1'b0);
    bus(1'b1, 8'h60, 32'h0000_1000);
    @(posedge CLK_SYS);
    chk(IRQ, 1'b1);
    bus(1'b1, 8'h55, 32'h0000_1000);
    @(posedge CLK_SYS);
    chk(IRQ, 1'b0);
    bus(1'b0, 8'h55, 32'h0);
    chk(rdat, 32'h0000_eff0);
    // Single-channel mode: only channel 0 counts and inserts idle cells.
    bus(1'b1, 8'h61, 32'h0000_0001);
    cells(4'hf, 4'hf, 4'hf, 1);
    chk(ins, 4'h1);
    bus(1'b0, 8'h1b, 32'h0);
    chk(rdat, 32'h2);
    bus(1'b0, 8'h1a, 32'h0);
    chk(rdat, 32'h0);
    // Test cells on channel 0 and a full buffer on channel 3 suppress idle insertion.
    bus(1'b1, 8'h61, 32'h0000_0002);
    TX_BUF_EMPTY <= 4'h7;
    cells(4'h0, 4'hf, 4'h0, 1);
    chk(ins, 4'h6);
    bus(1'b0, 8'h1f, 32'h0);
    chk(rdat, 32'h1);
    bus(1'b0, 8'h1e, 32'h0);
    chk(rdat, 32'h2);
    // A second reset in mid-run restores the documented values.
    RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    bus(1'b0, 8'h1e, 32'h0);
    chk(rdat, 32'h0000_fffc);
    bus(1'b0, 8'h55, 32'h0);
    chk(rdat, 32'h0);
    wrap_up();
  end
endmodule

// [src/acc_counters.sv]
// Top module: ATM cell traffic counters with roll-over flags, interrupt and an AHB-Lite register slave.
`timescale 1ns/10ps
// How it works
// - Assigned transmit cell counts per transmit processor.
// - Sixteen-bit counters wrap from 65535 to zero.
// - Tx assigned ch2/1/0 wrap set bits 14/13/12.
// - Empty buffer, no test cells: count idle.
// - Idle tx ch3..0 wrap set bits 11..8.
// - Count received assigned cells; ch3/2/1 bits 7/6/5.
// - All roll-over flags in one register at 0x55.
// - Counters read-only, reset to 0xFFFC.
// - Channel 0 counters valid in both modes.
// - Channels 1-3 counters meaningful only in four-channel mode.
// - Tx assigned ch3 wrap sets bit 15.
// - Rx assigned ch0 wrap sets bit 4.
module acc_counters (
  input  wire logic        CLK_SYS,          // Core clock, 200 MHz.
  input  wire logic        RST,              // Asynchronous reset, active high.
  // AHB-Lite slave.
  input  wire logic        HSEL,             // Slave select.
  input  wire logic [31:0] HADDR,            // Byte address.
  input  wire logic [1:0]  HTRANS,           // Transfer type.
  input  wire logic        HWRITE,           // Write when high.
  input  wire logic [2:0]  HSIZE,            // Transfer size, word only.
  input  wire logic [31:0] HWDATA,           // Write data.
  input  wire logic        HREADY,           // Bus ready in.
  output logic      [31:0] HRDATA,           // Read data, from a flop.
  output logic             HREADYOUT,        // Always ready.
  output logic             HRESP,            // Always OKAY.
  // Cell events, one-cycle pulses per channel.
  input  wire logic [3:0]  TX_ASSIGNED,      // Assigned cell sent from the same-numbered buffer.
  input  wire logic [3:0]  TX_SLOT,          // A cell slot is due on the line.
  input  wire logic [3:0]  TX_BUF_EMPTY,     // Transmit buffer holds no assigned cell.
  input  wire logic [3:0]  RX_ASSIGNED,      // Assigned cell received.
  output logic      [3:0]  TX_IDLE_INSERT,   // Send an idle cell in this slot.
  output logic             IRQ               // Level interrupt.
);

  // Counter array: index 4*group + channel.
  localparam int NCNT = acc_pkg::NUM_GRP * acc_pkg::NUM_CH;

  // Register map, as word indices on the bus (byte address is four times the index).
  // Index 0x18 to 0x1b hold the assigned transmit counters of channels 3 down to 0.
  // Index 0x1c to 0x1f hold the idle transmit counters of channels 3 down to 0.
  // Index 0x20 to 0x23 hold the assigned receive counters of channels 3 down to 0.
  // Index 0x55 holds the sticky roll-over flags; bits 3:0 are not used and read zero.
  // Index 0x60 holds the interrupt mask, one bit per roll-over flag.
  // Index 0x61 holds the mode bit and the four test cell enables.
  // Every register sits in bits 15:0 of its word; the upper half always reads zero.
  // Any other index reads zero and ignores writes, so software probing is harmless.
  //
  // Counter layout inside the array.
  // Entries 0 to 3 are the assigned transmit counters, entry k for channel k.
  // Entries 4 to 7 are the idle transmit counters, entry 4+k for channel k.
  // Entries 8 to 11 are the assigned receive counters, entry 8+k for channel k.
  // The bus decode runs the index backwards, because channel 3 has the lowest index.
  //
  // Timing on the cell side.
  // A pulse that is high at a rising edge counts once at that edge.
  // A pulse held high for several edges counts once per edge, which is what a
  // cell processor wants when it sends cells back to back.
  // The roll-over flag rises at the same edge at which its counter passes to zero.
  // The interrupt rises at that same edge, as it is registered from the next values.
  //
  // Timing on the bus side.
  // The slave never waits, so every transfer takes one address and one data cycle.
  // Read data is looked up in the address phase and stands in a flop for the data phase.
  // A read therefore shows the value that stood at the end of the address phase; an
  // event counted at that very edge is seen by the next read, not this one.
  // Writes land at the closing edge of the data phase.
  //
  // Limitations a user must know.
  // Counters cannot be preset or cleared by software; only reset brings them back.
  // In single-channel mode channels 1 to 3 freeze rather than clear, so their values
  // after a mode change are stale until a reset.
  // The roll-over register is cleared by writing one; a wrap in the same cycle wins,
  // so software never loses a flag to a race with its own clear.

  logic [15:0] cnt [NCNT];        // Counter values.
  logic [15:0] next_cnt [NCNT];   // Next counter values.
  logic [NCNT-1:0] inc;           // Counted event per counter.
  logic [NCNT-1:0] wrap;          // Counter passes from maximum to zero.
  logic [15:0] roll;              // Sticky roll-over flags.
  logic [15:0] next_roll;
  logic [15:0] mask;              // Interrupt mask, one enables a flag.
  logic [15:0] next_mask;
  logic [4:0]  ctrl;              // Mode and test cell enables.
  logic [4:0]  next_ctrl;
  logic        sts12c;            // Single-channel mode.
  logic [3:0]  tcg_en;            // Test cell generation per channel.
  logic [3:0]  ch_live;           // Channel counts in the current mode.

  // AHB address phase capture.
  logic        wr_pend;           // Write data phase follows.
  logic        next_wr_pend;
  logic [7:0]  wr_idx;            // Register index of the pending write.
  logic [7:0]  next_wr_idx;
  logic [31:0] next_hrdata;
  logic        addr_ok;           // Valid transfer in the address phase.
  logic [7:0]  a_idx;             // Index presented in the address phase.
  logic [15:0] wr_roll_clr;       // Flags cleared by the write now in data phase.

  assign sts12c = ctrl[acc_pkg::CTRL_STS12C_BIT];
  assign tcg_en = ctrl[acc_pkg::CTRL_TCG_LSB +: 4];

  // In single-channel mode channels 1-3 carry no meaning, so they are frozen. Channel 0 always counts.
  assign ch_live = sts12c ? 4'h1 : 4'hf;

  // Idle insertion is combinational so the cell processor sees it in the same slot.
  assign TX_IDLE_INSERT = TX_SLOT & TX_BUF_EMPTY & ~tcg_en & ch_live;

  // Event per counter and wrap detection.
  always_comb begin
    inc = '0;
    wrap = '0;
    for (int k = 0; k < acc_pkg::NUM_CH; k++) begin
      inc[k]     = TX_ASSIGNED[k] & ch_live[k];
      inc[4 + k] = TX_IDLE_INSERT[k];
      inc[8 + k] = RX_ASSIGNED[k] & ch_live[k];
    end
    for (int i = 0; i < NCNT; i++) begin
      wrap[i] = inc[i] && (cnt[i] == acc_pkg::CNT_MAX);
    end
  end

  // Counters step by one per event and wrap naturally; no bus path writes them.
  always_comb begin
    for (int i = 0; i < NCNT; i++) begin
      next_cnt[i] = inc[i] ? 16'(cnt[i] + 16'h0001) : cnt[i];
    end
  end

  // Counter registers.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NCNT; i++) begin
        cnt[i] <= acc_pkg::CNT_RST;
      end
    end else begin
      for (int i = 0; i < NCNT; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // Address phase decode; only word-aligned index bits matter.
  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign a_idx   = HADDR[9:2];

  // Flags that the pending write clears; writing one clears.
  assign wr_roll_clr = (wr_pend && wr_idx == acc_pkg::IDX_ROLL) ? HWDATA[15:0] : 16'h0000;

  // Roll-over flags: a wrap in the same cycle as a clear keeps the flag set.
  always_comb begin
    next_roll = roll & ~wr_roll_clr;
    for (int k = 0; k < acc_pkg::NUM_CH; k++) begin
      if (wrap[k]) begin
        next_roll[acc_pkg::RO_ATX_LSB + k] = 1'b1;
      end
      if (wrap[4 + k]) begin
        next_roll[acc_pkg::RO_ITX_LSB + k] = 1'b1;
      end
      if (wrap[8 + k]) begin
        next_roll[acc_pkg::RO_ARX_LSB + k] = 1'b1;
      end
    end
  end

  // Mask and control writes, plus the address phase capture for the bus.
  always_comb begin
    next_mask    = mask;
    next_ctrl    = ctrl;
    next_wr_pend = addr_ok && HWRITE;
    next_wr_idx  = addr_ok ? a_idx : wr_idx;
    if (wr_pend && wr_idx == acc_pkg::IDX_MASK) begin
      next_mask = HWDATA[15:0];
    end
    if (wr_pend && wr_idx == acc_pkg::IDX_CTRL) begin
      next_ctrl = HWDATA[4:0];
    end
  end

  // Read data is fetched in the address phase, so it stands in a flop for the data phase.
  // Unmapped indices read zero; a read never touches any counter.
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (addr_ok && !HWRITE) begin
      for (int k = 0; k < acc_pkg::NUM_CH; k++) begin
        if (a_idx == 8'(acc_pkg::IDX_ATX0 - 8'(k))) begin
          next_hrdata = {16'h0000, cnt[k]};
        end
        if (a_idx == 8'(acc_pkg::IDX_ITX0 - 8'(k))) begin
          next_hrdata = {16'h0000, cnt[4 + k]};
        end
        if (a_idx == 8'(acc_pkg::IDX_ARX0 - 8'(k))) begin
          next_hrdata = {16'h0000, cnt[8 + k]};
        end
      end
      case (a_idx)
        acc_pkg::IDX_ROLL: next_hrdata = {16'h0000, roll};
        acc_pkg::IDX_MASK: next_hrdata = {16'h0000, mask};
        acc_pkg::IDX_CTRL: next_hrdata = {27'h0, ctrl};
        default:           next_hrdata = next_hrdata;
      endcase
    end
  end

  // Register file and bus state.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      roll    <= acc_pkg::ROLL_RST;
      mask    <= acc_pkg::MASK_RST;
      ctrl    <= acc_pkg::CTRL_RST;
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      HRDATA  <= 32'h0000_0000;
      IRQ     <= 1'b0;
    end else begin
      roll    <= next_roll;
      mask    <= next_mask;
      ctrl    <= next_ctrl;
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
      HRDATA  <= next_hrdata;
      IRQ     <= |(next_roll & next_mask);
    end
  end

  // The slave never inserts wait states and never errors.
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Checks on counters, flags and the bus answer.
  default clocking dcb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // An assigned cell on a live channel steps its counter by exactly one.
  a_tx_assigned_step: assert property (TX_ASSIGNED[1] && !sts12c |=> cnt[1] == 16'($past(cnt[1]) + 16'h0001))
    else $error("Assigned tx counter 1 did not step.");

  // Channel 0 assigned transmit counter steps in every mode.
  a_atx0_step: assert property (TX_ASSIGNED[0] |=> cnt[0] == 16'($past(cnt[0]) + 16'h0001))
    else $error("Assigned tx counter 0 did not step.");

  // Received assigned cells step the receive counter of a live channel.
  a_rx_step: assert property (RX_ASSIGNED[2] && !sts12c |=> cnt[10] == 16'($past(cnt[10]) + 16'h0001))
    else $error("Assigned rx counter 2 did not step.");

  // Idle insertion needs a due slot, an empty buffer and no test cells.
  a_idle_gate: assert property (TX_IDLE_INSERT[1] |-> TX_SLOT[1] && TX_BUF_EMPTY[1] && !tcg_en[1])
    else $error("Idle cell inserted without its conditions.");

  // Test cell generation on a channel suppresses its idle cells.
  a_idle_block: assert property (tcg_en[2] |-> !TX_IDLE_INSERT[2])
    else $error("Idle cell inserted while test cells enabled.");

  // The transmit counter passes from its top value to zero.
  a_atx_wrap_zero: assert property (inc[0] && cnt[0] == 16'hffff |=> cnt[0] == 16'h0000)
    else $error("Tx counter 0 did not wrap to zero.");

  // The transmit channel 0 wraps and the receive channel 3 wrap each land on their own flag.
  a_atx0_roll_bit: assert property (wrap[0] |=> roll[12])
    else $error("Tx assigned ch0 wrap did not set bit 12.");
  a_itx0_roll_bit: assert property (wrap[4] |=> roll[8])
    else $error("Idle tx ch0 wrap did not set bit 8.");
  a_arx3_roll_bit: assert property (wrap[11] |=> roll[7])
    else $error("Rx assigned ch3 wrap did not set bit 7.");

  // A flag stays set until software writes one to it.
  a_roll_sticky: assert property (roll[12] && !wr_roll_clr[12] |=> roll[12])
    else $error("Roll-over flag dropped without a clear.");

  // The unused low flags never rise.
  a_roll_low_zero: assert property (roll[3:0] == 4'h0)
    else $error("Unused roll-over bits set.");

  // A read of a counter in a quiet cycle leaves it alone.
  a_read_no_touch: assert property (addr_ok && !HWRITE && !inc[0] |=> cnt[0] == $past(cnt[0]))
    else $error("Read disturbed a counter.");

  // The interrupt level matches the unmasked flags at all times.
  a_irq_match: assert property (IRQ == |(roll & mask))
    else $error("Interrupt does not match unmasked flags.");

  // Transmit channel 1 freezes in single-channel mode as well.
  a_mode_freeze_tx: assert property (sts12c && TX_ASSIGNED[1] |=> $stable(cnt[1]))
    else $error("Channel 1 counted in single-channel mode.");

  // The bus answer is always ready and OKAY.
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("Bus answer not ready or not OKAY.");

  // A wrap on the receive side reaches zero.
  a_counter_wrap: assert property (inc[8] && cnt[8] == 16'hffff |=> cnt[8] == 16'h0000)
    else $error("Rx counter 0 did not wrap to zero.");
  // Transmit channel 2 wrap raises bit 14.
  a_atx_roll_bit: assert property (wrap[2] |=> roll[14])
    else $error("Tx assigned ch2 wrap did not set bit 14.");
  // An idle slot on channel 0 is counted once.
  a_idle_counts: assert property (TX_SLOT[0] && TX_BUF_EMPTY[0] && !tcg_en[0]
                                  |=> cnt[4] == 16'($past(cnt[4]) + 16'h0001))
    else $error("Idle cell slot not counted.");
  a_idle_roll_bit: assert property (wrap[7] |=> roll[11])
    else $error("Idle tx ch3 wrap did not set bit 11.");
  a_arx_roll_bit: assert property (wrap[9] |=> roll[5])
    else $error("Rx assigned ch1 wrap did not set bit 5.");
  a_roll_read: assert property (addr_ok && !HWRITE && a_idx == acc_pkg::IDX_ROLL
                                |=> HRDATA == {16'h0000, $past(roll)})
    else $error("Roll-over read returned the wrong value.");
  a_counter_hold: assert property (!inc[1] |=> $stable(cnt[1]))
    else $error("Counter changed without an event.");
  a_mode_freeze: assert property (sts12c && RX_ASSIGNED[3] |=> $stable(cnt[11]))
    else $error("Channel 3 counted in single-channel mode.");
  a_ch0_both_modes: assert property (sts12c && RX_ASSIGNED[0] |=> cnt[8] != $past(cnt[8]))
    else $error("Channel 0 frozen in single-channel mode.");
  a_atx3_roll_bit: assert property (wrap[3] |=> roll[15])
    else $error("Tx assigned ch3 wrap did not set bit 15.");
  // Receive channel 0 wrap raises bit 4; the set wins over a clear in the same cycle.
  a_arx0_roll_bit: assert property (wrap[8] |=> roll[4])
    else $error("Rx assigned ch0 wrap did not set bit 4.");
  a_irq_level: assert property (roll == 16'h0000 ##1 roll == 16'h0000 |-> !IRQ)
    else $error("Interrupt high with no flag set.");

  c_any_wrap: cover property (|wrap);
  c_idle_insert: cover property (|TX_IDLE_INSERT);
  c_clear_collide: cover property (|(wr_roll_clr & next_roll));
  c_irq_raise: cover property (!IRQ ##1 IRQ);
  c_single_mode: cover property (sts12c && |inc);

endmodule

// [src/acc_pkg.sv]
// Package with register indices, field positions and reset values for the ATM cell traffic counters.
package acc_pkg;

  // Width of every cell counter and its value after reset.
  localparam int          CNT_W     = 16;
  localparam logic [15:0] CNT_RST   = 16'hfffc;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam int          NUM_CH    = 4;
  localparam int          NUM_GRP   = 3;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_ATX3  = 8'h18;
  localparam logic [7:0] IDX_ATX2  = 8'h19;
  localparam logic [7:0] IDX_ATX1  = 8'h1a;
  localparam logic [7:0] IDX_ATX0  = 8'h1b;
  localparam logic [7:0] IDX_ITX3  = 8'h1c;
  localparam logic [7:0] IDX_ITX2  = 8'h1d;
  localparam logic [7:0] IDX_ITX1  = 8'h1e;
  localparam logic [7:0] IDX_ITX0  = 8'h1f;
  localparam logic [7:0] IDX_ARX3  = 8'h20;
  localparam logic [7:0] IDX_ARX2  = 8'h21;
  localparam logic [7:0] IDX_ARX1  = 8'h22;
  localparam logic [7:0] IDX_ARX0  = 8'h23;
  localparam logic [7:0] IDX_ROLL  = 8'h55;
  localparam logic [7:0] IDX_MASK  = 8'h60;
  localparam logic [7:0] IDX_CTRL  = 8'h61;

  // Lowest roll-over bit of each counter group; channel k adds k.
  localparam int RO_ATX_LSB = 12;
  localparam int RO_ITX_LSB = 8;
  localparam int RO_ARX_LSB = 4;

  // Reset values of the roll-over, mask and control registers.
  localparam logic [15:0] ROLL_RST  = 16'h0000;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [4:0]  CTRL_RST  = 5'h00;

  // Control register fields: single-channel mode flag and per-channel test cell enables.
  localparam int CTRL_STS12C_BIT = 0;
  localparam int CTRL_TCG_LSB    = 1;

  // Counter groups kept in the counter array, four channels each.
  typedef enum logic [1:0] {
    GRP_ATX,
    GRP_ITX,
    GRP_ARX
  } acc_grp_t;

endpackage
